// [design/mseq_start_sequencer.sv]
// module: start sequencer decision machine with its register slave
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

// How it works
// [R01] after reset stay in power-on, requesting parameter load until done
// [R02] zero reference: rest in sleep or standby from select bit and wake pin
// [R03] nonzero reference leaves low power for the speed detect decision
// [R04] a direction change in the run states goes to the method decision
// [R05] method 0 goes to speed detect decision, 1 to the handoff compare
// [R06] speed detect enabled: stationary check; disabled: brake decision
// [R07] emf below either threshold counts as stationary, go to brake decision
// [R08] forward spin to resync decision, reverse spin to reverse drive decision
// [R09] resync: closed loop if fast enough, else open loop acceleration
// [R10] resync off: coast and/or brake, then start as if stationary
// [R11] reverse drive decelerates through zero, then accelerates commanded way
// [R12] reverse drive off: coast and/or brake, then stationary start-up
// [R13] stationary: optional brake, start-up method, then open loop
// [R14] start-up method chosen from align, double align, ipd, slow cycle
// [R15] in forward-reverse profile, pin and bit direction commands are ignored
// [R16] software keeps current limited and supply surge guarded (outside)
// [R17] resync on: compare speed to resync threshold; off: coast decision
// [R18] reverse drive on: handoff compare; off: coast decision
// [R19] coast on: all switches off for coast time; off: brake decision
// [R20] brake on: run brake routine; off: go to start-up
// [R21] explicit state machine, one decision per cycle, waits on inputs
module mseq_start_sequencer (
    input  wire logic                  clk_sys_i,
    input  wire logic                  srst_i,
    input  wire logic                  wake_pin_i,
    input  wire logic                  dir_pin_i,
    input  wire mseq_pkg::mseq_sense_s sense_i,
    output mseq_pkg::mseq_drive_s      drive_o,
    input  wire logic [4:0]            s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output logic [1:0]                 s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    input  wire logic [4:0]            s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic [31:0]                s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i
);
    import mseq_pkg::*;

    // ---------------- register slave ----------------
    logic [31:0] ctrl_ff, thr_stat_ff, thr_loop_ff, coast_time_ff;
    logic [31:0] nxt_ctrl, nxt_thr_stat, nxt_thr_loop, nxt_coast_time;
    logic        aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
    logic        nxt_aw_ok, nxt_w_ok, nxt_bvalid, nxt_rvalid;
    logic [4:0]  awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [3:0]  wstrb_ff, nxt_wstrb;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] status_word;
    mseq_state_e state_ff, nxt_state;
    logic        dir_ff, nxt_dir;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign s_axi_awready_o = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready_o  = !w_ok_ff && !bvalid_ff;
    assign s_axi_arready_o = !rvalid_ff;
    assign s_axi_bvalid_o  = bvalid_ff;
    assign s_axi_bresp_o   = bresp_ff;
    assign s_axi_rvalid_o  = rvalid_ff;
    assign s_axi_rdata_o   = rdata_ff;
    assign s_axi_rresp_o   = rresp_ff;
    assign status_word     = {25'h0, dir_ff, 1'b0, state_ff};

    always_comb begin
        nxt_aw_ok      = aw_ok_ff;
        nxt_awaddr     = awaddr_ff;
        nxt_w_ok       = w_ok_ff;
        nxt_wdata      = wdata_ff;
        nxt_wstrb      = wstrb_ff;
        nxt_bvalid     = bvalid_ff;
        nxt_bresp      = bresp_ff;
        nxt_rvalid     = rvalid_ff;
        nxt_rdata      = rdata_ff;
        nxt_rresp      = rresp_ff;
        nxt_ctrl       = ctrl_ff;
        nxt_thr_stat   = thr_stat_ff;
        nxt_thr_loop   = thr_loop_ff;
        nxt_coast_time = coast_time_ff;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            nxt_aw_ok  = 1'b1;
            nxt_awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            nxt_w_ok  = 1'b1;
            nxt_wdata = s_axi_wdata_i;
            nxt_wstrb = s_axi_wstrb_i;
        end
        if (aw_ok_ff && w_ok_ff && !bvalid_ff) begin
            nxt_aw_ok  = 1'b0;
            nxt_w_ok   = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = RESP_OKAY;
            case (awaddr_ff)
                OFF_CTRL:
                    nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff);
                OFF_THR_STAT:
                    nxt_thr_stat = merge(thr_stat_ff, wdata_ff, wstrb_ff);
                OFF_THR_LOOP:
                    nxt_thr_loop = merge(thr_loop_ff, wdata_ff, wstrb_ff);
                OFF_COAST_TIME:
                    nxt_coast_time = merge(coast_time_ff, wdata_ff, wstrb_ff);
                default:
                    nxt_bresp = RESP_SLVERR;
            endcase
        end else if (bvalid_ff && s_axi_bready_i) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            case (s_axi_araddr_i)
                OFF_CTRL:       nxt_rdata = ctrl_ff;
                OFF_THR_STAT:   nxt_rdata = thr_stat_ff;
                OFF_THR_LOOP:   nxt_rdata = thr_loop_ff;
                OFF_COAST_TIME: nxt_rdata = coast_time_ff;
                OFF_STATUS:     nxt_rdata = status_word;
                default: begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready_i) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            aw_ok_ff      <= 1'b0;
            awaddr_ff     <= 5'h00;
            w_ok_ff       <= 1'b0;
            wdata_ff      <= 32'h0;
            wstrb_ff      <= 4'h0;
            bvalid_ff     <= 1'b0;
            bresp_ff      <= RESP_OKAY;
            rvalid_ff     <= 1'b0;
            rdata_ff      <= 32'h0;
            rresp_ff      <= RESP_OKAY;
            ctrl_ff       <= RST_CTRL;
            thr_stat_ff   <= RST_THR_STAT;
            thr_loop_ff   <= RST_THR_LOOP;
            coast_time_ff <= RST_COAST_TIME;
        end else begin
            aw_ok_ff      <= nxt_aw_ok;
            awaddr_ff     <= nxt_awaddr;
            w_ok_ff       <= nxt_w_ok;
            wdata_ff      <= nxt_wdata;
            wstrb_ff      <= nxt_wstrb;
            bvalid_ff     <= nxt_bvalid;
            bresp_ff      <= nxt_bresp;
            rvalid_ff     <= nxt_rvalid;
            rdata_ff      <= nxt_rdata;
            rresp_ff      <= nxt_rresp;
            ctrl_ff       <= nxt_ctrl;
            thr_stat_ff   <= nxt_thr_stat;
            thr_loop_ff   <= nxt_thr_loop;
            coast_time_ff <= nxt_coast_time;
        end
    end

    // ---------------- pin synchronisers ----------------
    logic [1:0] wake_sync_ff, dir_sync_ff;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wake_sync_ff <= 2'b00;
            dir_sync_ff  <= 2'b00;
        end else begin
            wake_sync_ff <= {wake_sync_ff[0], wake_pin_i};
            dir_sync_ff  <= {dir_sync_ff[0], dir_pin_i};
        end
    end

    // ---------------- decision machine ----------------
    logic [15:0] stat_thr, fg_thr, handoff_thr, resync_thr;
    logic        fwd_rev_prof, dir_src, dir_event, run_state, ref_zero;
    logic [15:0] coast_cnt_ff, nxt_coast_cnt;
    mseq_drive_s drive_ff, nxt_drive;

    assign stat_thr     = thr_stat_ff[15:0];
    assign fg_thr       = thr_stat_ff[31:16];
    assign handoff_thr  = thr_loop_ff[15:0];
    assign resync_thr   = thr_loop_ff[31:16];
    assign fwd_rev_prof = ctrl_ff[CTL_FWDREV];
    assign dir_src      = dir_sync_ff[1] ^ ctrl_ff[CTL_DIR_BIT];
    assign ref_zero     = (sense_i.ref_level == 16'h0000);
    assign run_state    = (state_ff == S_OPEN_LOOP) ||
                          (state_ff == S_CLOSED_LOOP);
    // in forward-reverse profile the pin and bit are not looked at
    assign dir_event    = !fwd_rev_prof && (dir_src != dir_ff); // R15
    assign drive_o      = drive_ff;

    always_comb begin
        nxt_state     = state_ff;
        nxt_dir       = dir_ff;
        nxt_coast_cnt = coast_cnt_ff;
        // a pending change waits until low power or a run state takes it
        if (dir_event && (run_state || state_ff == S_LOW_PWR)) begin
            nxt_dir = dir_src; // R15
        end
        case (state_ff)
            S_PWR_ON: if (sense_i.cfg_loaded) nxt_state = S_LOW_PWR; // R01
            S_LOW_PWR: begin
                if (!ref_zero) nxt_state = S_SDET_EN; // R02 R03
            end
            S_SDET_EN: begin
                nxt_state = ctrl_ff[CTL_SDET_EN] ? S_STAT_CHK
                                                 : S_BRAKE_EN; // R06
            end
            S_STAT_CHK: begin
                // held until the speed detect result is valid
                if (sense_i.isd_valid) begin // R21
                    nxt_state = (sense_i.emf_level < stat_thr ||
                                 sense_i.emf_level < fg_thr)
                                ? S_BRAKE_EN : S_DIR_CHK; // R07
                end
            end
            S_DIR_CHK: begin
                nxt_state = sense_i.spin_fwd ? S_RESYNC_EN : S_REV_EN; // R08
            end
            S_RESYNC_EN: begin
                nxt_state = ctrl_ff[CTL_RESYNC_EN] ? S_RESYNC_CMP
                                                   : S_COAST_EN; // R10 R17
            end
            S_RESYNC_CMP: begin
                nxt_state = (sense_i.speed > resync_thr) ? S_CLOSED_LOOP
                                                         : S_OPEN_LOOP; // R09
            end
            S_REV_EN: begin
                nxt_state = ctrl_ff[CTL_REV_EN] ? S_HANDOFF_CMP
                                                : S_COAST_EN; // R12 R18
            end
            S_HANDOFF_CMP: begin
                nxt_state = (sense_i.speed > handoff_thr) ? S_REV_CL_DEC
                                                          : S_REV_OL_DEC; // R11
            end
            S_REV_CL_DEC: begin
                if (sense_i.speed <= handoff_thr) nxt_state = S_REV_OL_DEC; // R11
            end
            S_REV_OL_DEC: begin
                if (sense_i.zero_cross) nxt_state = S_OPEN_LOOP; // R11
            end
            S_COAST_EN: begin
                nxt_coast_cnt = coast_time_ff[15:0];
                nxt_state = ctrl_ff[CTL_COAST_EN] ? S_COAST : S_BRAKE_EN; // R19
            end
            S_COAST: begin
                if (coast_cnt_ff <= 16'h0001) begin
                    nxt_state = S_BRAKE_EN; // R19
                end else begin
                    nxt_coast_cnt = coast_cnt_ff - 16'h0001;
                end
            end
            S_BRAKE_EN: begin
                nxt_state = ctrl_ff[CTL_BRAKE_EN] ? S_BRAKE : S_STARTUP; // R20
            end
            S_BRAKE: if (sense_i.brake_done) nxt_state = S_STARTUP; // R13
            S_STARTUP: if (sense_i.startup_done) nxt_state = S_OPEN_LOOP; // R13
            S_OPEN_LOOP: begin
                if (sense_i.speed > handoff_thr) nxt_state = S_CLOSED_LOOP;
            end
            S_CLOSED_LOOP: ;
            S_DIR_MODE: begin
                nxt_state = ctrl_ff[CTL_DIR_MODE] ? S_HANDOFF_CMP
                                                  : S_SDET_EN; // R05
            end
            default: nxt_state = S_PWR_ON;
        endcase
        if (run_state) begin
            if (ref_zero) begin
                nxt_state = S_LOW_PWR; // R02
            end else if (dir_event) begin
                nxt_state = S_DIR_MODE; // R04
            end
        end
    end

    always_comb begin
        nxt_drive              = '0;
        nxt_drive.dir          = nxt_dir;
        nxt_drive.start_method = mseq_start_e'(ctrl_ff[CTL_START_LSB +: 2]); // R14
        case (nxt_state)
            S_PWR_ON:  nxt_drive.param_load = 1'b1; // R01
            S_LOW_PWR: begin
                // sleep only when selected and the wake pin is low
                nxt_drive.sleep   = ctrl_ff[CTL_SLEEP_SEL] &&
                                    !wake_sync_ff[1]; // R02
                nxt_drive.standby = !nxt_drive.sleep; // R02
            end
            S_STAT_CHK:    nxt_drive.isd_req     = 1'b1;
            S_COAST:       nxt_drive.bridge_off  = 1'b1; // R19
            S_BRAKE:       nxt_drive.brake       = 1'b1; // R20
            S_STARTUP:     nxt_drive.startup     = 1'b1; // R14
            S_OPEN_LOOP:   nxt_drive.open_loop   = 1'b1;
            S_CLOSED_LOOP: nxt_drive.closed_loop = 1'b1;
            S_REV_CL_DEC:  nxt_drive.rev_decel   = 1'b1;
            S_REV_OL_DEC:  nxt_drive.rev_decel   = 1'b1;
            default:       nxt_drive.dir         = nxt_dir;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_ff     <= S_PWR_ON; // R01
            dir_ff       <= 1'b0;
            coast_cnt_ff <= 16'h0000;
            drive_ff     <= '0;
        end else begin
            state_ff     <= nxt_state; // R21
            dir_ff       <= nxt_dir;
            coast_cnt_ff <= nxt_coast_cnt;
            drive_ff     <= nxt_drive;
        end
    end

    // ---------------- checks ----------------
    por_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R01
        state_ff == S_PWR_ON && !sense_i.cfg_loaded |=>
            state_ff == S_PWR_ON && drive_o.param_load)
        else $error("power-on left before parameters loaded");
    low_pwr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R02
        state_ff == S_LOW_PWR && ref_zero |=>
            state_ff == S_LOW_PWR && (drive_o.sleep ^ drive_o.standby))
        else $error("low power not held at zero reference");
    wake_up_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R03
        state_ff == S_LOW_PWR && !ref_zero |=> state_ff == S_SDET_EN)
        else $error("nonzero reference did not leave low power");
    dir_cmd_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R04
        run_state && !ref_zero && dir_event |=> state_ff == S_DIR_MODE
            ##1 state_ff == (ctrl_ff[CTL_DIR_MODE] ? S_HANDOFF_CMP
                                                   : S_SDET_EN))
        else $error("direction change not routed by its method");
    sdet_route_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R06
        state_ff == S_SDET_EN |=> state_ff == (ctrl_ff[CTL_SDET_EN] ?
            S_STAT_CHK : S_BRAKE_EN))
        else $error("speed detect decision misrouted");
    stat_route_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R07
        state_ff == S_STAT_CHK && sense_i.isd_valid &&
        sense_i.emf_level < stat_thr |=> state_ff == S_BRAKE_EN)
        else $error("stationary motor not sent to brake decision");
    resync_cmp_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R09
        state_ff == S_RESYNC_CMP && sense_i.speed > resync_thr |=>
            state_ff == S_CLOSED_LOOP ##1 drive_o.closed_loop || ref_zero)
        else $error("fast forward motor not resynchronised");
    coast_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R19
        state_ff == S_COAST && coast_cnt_ff > 16'h0001 |=>
            state_ff == S_COAST && drive_o.bridge_off)
        else $error("coast ended before its time");
    brake_route_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R20
        state_ff == S_BRAKE_EN |=> state_ff == (ctrl_ff[CTL_BRAKE_EN] ?
            S_BRAKE : S_STARTUP))
        else $error("brake decision misrouted");
    prof_dir_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R15
        fwd_rev_prof |=> $stable(dir_ff))
        else $error("direction moved in forward-reverse profile");

endmodule

// [design/mseq_pkg.sv]
// package: register map, field layout, states and carriers of the start sequencer
package mseq_pkg;

    localparam int          AXI_AW         = 5;
    localparam logic [4:0]  OFF_CTRL       = 5'h00;
    localparam logic [4:0]  OFF_THR_STAT   = 5'h04;
    localparam logic [4:0]  OFF_THR_LOOP   = 5'h08;
    localparam logic [4:0]  OFF_COAST_TIME = 5'h0C;
    localparam logic [4:0]  OFF_STATUS     = 5'h10;

    localparam int          CTL_SLEEP_SEL  = 0;
    localparam int          CTL_DIR_MODE   = 1;
    localparam int          CTL_SDET_EN    = 2;
    localparam int          CTL_RESYNC_EN  = 3;
    localparam int          CTL_REV_EN     = 4;
    localparam int          CTL_COAST_EN   = 5;
    localparam int          CTL_BRAKE_EN   = 6;
    localparam int          CTL_START_LSB  = 8;
    localparam int          CTL_FWDREV     = 10;
    localparam int          CTL_DIR_BIT    = 11;

    localparam logic [31:0] RST_CTRL       = 32'h0000_0004;
    localparam logic [31:0] RST_THR_STAT   = 32'h0010_0010;
    localparam logic [31:0] RST_THR_LOOP   = 32'h0080_0100;
    localparam logic [31:0] RST_COAST_TIME = 32'h0000_0100;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        ST_ALIGN  = 2'b00,
        ST_DALIGN = 2'b01,
        ST_IPD    = 2'b10,
        ST_SLOW   = 2'b11
    } mseq_start_e;

    typedef enum logic [4:0] {
        S_PWR_ON      = 5'b00000,
        S_LOW_PWR     = 5'b00001,
        S_SDET_EN     = 5'b00010,
        S_STAT_CHK    = 5'b00011,
        S_DIR_CHK     = 5'b00100,
        S_RESYNC_EN   = 5'b00101,
        S_RESYNC_CMP  = 5'b00110,
        S_REV_EN      = 5'b00111,
        S_HANDOFF_CMP = 5'b01000,
        S_REV_CL_DEC  = 5'b01001,
        S_REV_OL_DEC  = 5'b01010,
        S_COAST_EN    = 5'b01011,
        S_COAST       = 5'b01100,
        S_BRAKE_EN    = 5'b01101,
        S_BRAKE       = 5'b01110,
        S_STARTUP     = 5'b01111,
        S_OPEN_LOOP   = 5'b10000,
        S_CLOSED_LOOP = 5'b10001,
        S_DIR_MODE    = 5'b10010
    } mseq_state_e;

    typedef struct packed {
        logic        cfg_loaded;
        logic [15:0] ref_level;
        logic        isd_valid;
        logic [15:0] emf_level;
        logic [15:0] speed;
        logic        spin_fwd;
        logic        zero_cross;
        logic        brake_done;
        logic        startup_done;
    } mseq_sense_s;

    typedef struct packed {
        logic        param_load;
        logic        sleep;
        logic        standby;
        logic        isd_req;
        logic        bridge_off;
        logic        brake;
        logic        startup;
        mseq_start_e start_method;
        logic        open_loop;
        logic        closed_loop;
        logic        rev_decel;
        logic        dir;
    } mseq_drive_s;

endpackage

// [tb/mseq_motor_model.sv]
// motor and bridge stand-in: answers detect, brake, start-up and reversal
`timescale 1ns/1ps
module mseq_motor_model (
    input  wire logic                  clk_sys_i,
    input  wire mseq_pkg::mseq_drive_s drive_i,
    input  wire logic [15:0]           emf_i,
    input  wire logic [15:0]           speed_i,
    input  wire logic                  fwd_i,
    input  wire logic [15:0]           ref_i,
    input  wire logic [3:0]            dly_i,
    output mseq_pkg::mseq_sense_s      sense_o
);
    import mseq_pkg::*;
    int unsigned cnt;
    mseq_drive_s prv;
    logic        act;
    logic        done;
    assign act = drive_i.isd_req | drive_i.brake | drive_i.startup
               | drive_i.rev_decel | drive_i.param_load;
    assign done = cnt >= dly_i;
    // each answer restarts its delay when the machine changes request
    always @(posedge clk_sys_i) begin
        cnt <= (act && drive_i === prv) ? cnt + 1 : 0;
        prv <= drive_i;
    end
    always_comb begin
        sense_o = '0;
        sense_o.cfg_loaded = drive_i.param_load & done;
        sense_o.ref_level = ref_i;
        sense_o.isd_valid = drive_i.isd_req & done;
        // stale emf is inverted so a late sample cannot pass by luck
        sense_o.emf_level = sense_o.isd_valid ? emf_i : ~emf_i;
        sense_o.speed = speed_i;
        sense_o.spin_fwd = fwd_i;
        sense_o.zero_cross = drive_i.rev_decel & done;
        sense_o.brake_done = drive_i.brake & done;
        sense_o.startup_done = drive_i.startup & done;
    end
endmodule

// [tb/motor_start_sequencer_tb.sv]
// self-checking bench for the start sequencer against a path model
`timescale 1ns/1ps
module motor_start_sequencer_tb;
    import mseq_pkg::*;
    logic clk, srst, wake, dpin, awv, wv, bry, arv, rry, clr, fwd;
    logic awr, wr, bv, arr, rv;
    logic [4:0] awa, ara, seen, e;
    logic [31:0] wd, rd, d, c;
    logic [3:0] ws, dly;
    logic [1:0] br, rr, r;
    logic [15:0] emf, spd, refl;
    mseq_sense_s sense;
    mseq_drive_s drv;
    int error_cnt, n_tests, cyc, ccnt, i, n, k, fast;
    logic [4:0] offs [4] = '{OFF_CTRL, OFF_THR_STAT, OFF_THR_LOOP,
                             OFF_COAST_TIME};
    logic [31:0] rstv [4] = '{RST_CTRL, RST_THR_STAT, RST_THR_LOOP,
                              RST_COAST_TIME};
    mseq_start_sequencer mseq_start_sequencer_inst (
        .clk_sys_i(clk), .srst_i(srst), .wake_pin_i(wake),
        .dir_pin_i(dpin), .sense_i(sense), .drive_o(drv),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rry));
    mseq_motor_model mseq_motor_model_inst (
        .clk_sys_i(clk), .drive_i(drv), .emf_i(emf), .speed_i(spd),
        .fwd_i(fwd), .ref_i(refl), .dly_i(dly), .sense_o(sense));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    // handshakes are judged at the falling edge, where inputs are settled
    task automatic axw(input logic [4:0] a, input logic [31:0] v);
        logic ha, hw, dn;
        @(posedge clk);
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        do begin
            @(negedge clk);
            ha = awv & awr; hw = wv & wr; dn = bv; r = br;
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
        end while (!dn);
        bry <= 1'b0;
    endtask
    task automatic axr(input logic [4:0] a);
        logic ha, dn;
        @(posedge clk);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        do begin
            @(negedge clk);
            ha = arv & arr; dn = rv; d = rd; r = rr;
            @(posedge clk);
            if (ha) arv <= 1'b0;
        end while (!dn);
        rry <= 1'b0;
    endtask
    function automatic logic cond(input int m);
        case (m)
            0: return drv.open_loop | drv.closed_loop;
            1: return drv.sleep | drv.standby;
            default: return !(drv.open_loop | drv.closed_loop);
        endcase
    endfunction
    task automatic wt(input int m);
        for (int j = 0; j < 4000 && cond(m) !== 1'b1; j++) @(negedge clk);
        chk(cond(m), 1, "wait");
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (clr) begin
            seen <= '0;
            ccnt <= 0;
        end else begin
            seen <= seen | {drv.isd_req, drv.rev_decel, drv.startup,
                            drv.brake, drv.bridge_off};
            ccnt <= ccnt + drv.bridge_off;
        end
        if (cyc == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        {srst, wake, dpin, awv, wv, bry, arv, rry, clr, fwd} = 10'h201;
        {awa, ara, wd, emf, spd, refl, dly, ws} = '0;
        ws = 4'hF;
        error_cnt = 0; n_tests = 0; cyc = 0;
        void'($urandom(8929));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        dly <= 4'h3;
        // the first edge after release is the one that loads the drive word
        @(posedge clk);
        @(negedge clk);
        chk(drv.param_load, 1, "load");
        wt(1);
        for (i = 0; i < 4; i++) begin
            axr(offs[i]);
            chk(d, rstv[i], "reset value");
        end
        axr(5'h14);
        chk(d, 32'h0, "unmapped data");
        chk(r, RESP_SLVERR, "unmapped");
        axw(OFF_STATUS, 32'h0);
        chk(r, RESP_SLVERR, "read only");
        $display("register test done");
        for (i = 0; i < 12; i++) begin
            c = $urandom & 32'h0000_037F;
            n = $urandom_range(1, 8); k = $urandom_range(0, 2);
            fast = $urandom_range(0, 1);
            axw(OFF_CTRL, c);
            axw(OFF_COAST_TIME, n);
            // stationary emf stays below both thresholds of 0x10
            emf <= k ? 16'h20 + $urandom_range(0, 255) : $urandom_range(0, 15);
            fwd <= (k == 1); spd <= (k == 1 && fast) ? 16'h90 : 16'h40;
            dly <= $urandom_range(1, 9); wake <= $urandom_range(0, 1);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            refl <= 16'h200;
            wt(0);
            if (c[2] && k == 1 && c[3]) e = 5'b10000;
            else if (c[2] && k == 2 && c[4]) e = 5'b11000;
            else e = {c[2], 2'b01, c[6], c[2] & (k != 0) & c[5]};
            chk(seen, e, "path");
            chk(drv.closed_loop, e == 5'b10000 && fast, "resync");
            chk(ccnt, e[0] ? n : 0, "coast time");
            chk(drv.start_method, c[9:8], "method");
            axr(OFF_STATUS);
            chk(d[4:0], drv.closed_loop ? S_CLOSED_LOOP : S_OPEN_LOOP, "st");
            clr <= 1'b1;
            if (i % 2) begin
                axw(OFF_CTRL, c | 32'h400);
                clr <= 1'b1; dpin <= ~dpin;
                @(posedge clk);
                clr <= 1'b0;
                repeat (30) @(posedge clk);
                @(negedge clk);
                chk({drv.dir, seen}, {~dpin, 5'h0}, "frozen");
                dpin <= ~dpin;
            end else begin
                dpin <= ~dpin;
                @(posedge clk);
                clr <= 1'b0;
                wt(2);
                wt(0);
                chk(drv.dir, dpin, "dir");
                chk(c[1] ? seen[3] : seen[4] == c[2], 1, "dir path");
            end
            refl <= 16'h0;
            wt(1);
            chk({drv.sleep, drv.standby}, c[0] & ~wake ? 2 : 1, "rest");
            $display("scenario %0d done", i);
        end
        summarize();
    end
endmodule
